// ---- hdl/jbs_defs.svh ----
// Constants of the boundary-scan test port: opcodes, register lengths and reset values
`ifndef JBS_DEFS_SVH
`define JBS_DEFS_SVH

`define JBS_IR_LEN          10
`define JBS_IR_CAPTURE      10'h001
`define JBS_IR_EXTEST       10'h000
`define JBS_IR_SAMPLE       10'h055
`define JBS_IR_IDCODE       10'h006
`define JBS_IR_USERCODE     10'h007
`define JBS_IR_CFG_LOAD     10'h002
`define JBS_IR_BYPASS       10'h3ff
`define JBS_IR_RESET_VAL    10'h006
`define JBS_ID_LEN          32
`define JBS_UC_LEN          32
`define JBS_UC_USER_LEN     7
`define JBS_UC_FIXED_LEN    25
`define JBS_BSR_LEN_DEF     690
`define JBS_CELLS_PER_PIN   3
`define JBS_CFG_W_DEF       8
`define JBS_BYPASS_CAPTURE  1'b0

`endif

// ---- hdl/jbs_pkg.sv ----
// Types shared by the boundary-scan test port
`default_nettype none
package jbs_pkg;

  typedef enum logic [3:0] {
    st_reset     = 4'h0,
    st_idle      = 4'h1,
    st_sel_dr    = 4'h2,
    st_cap_dr    = 4'h3,
    st_shift_dr  = 4'h4,
    st_exit1_dr  = 4'h5,
    st_pause_dr  = 4'h6,
    st_exit2_dr  = 4'h7,
    st_upd_dr    = 4'h8,
    st_sel_ir    = 4'h9,
    st_cap_ir    = 4'ha,
    st_shift_ir  = 4'hb,
    st_exit1_ir  = 4'hc,
    st_pause_ir  = 4'hd,
    st_exit2_ir  = 4'he,
    st_upd_ir    = 4'hf
  } jbs_tap_state_type;

  typedef enum logic [2:0] {
    sel_bypass = 3'h0,
    sel_bsr    = 3'h1,
    sel_id     = 3'h2,
    sel_uc     = 3'h3,
    sel_cfg    = 3'h4
  } jbs_dr_sel_type;

endpackage
`default_nettype wire

// ---- hdl/jbs_sync.sv ----
// Two-stage synchroniser for quasi-static levels, any width
`timescale 1ns/10ps
`include "jbs_defs.svh"
`default_nettype none
module jbs_sync #(
  parameter int W = 1
) (
  input  wire logic         clk_in,    // Destination clock
  input  wire logic         reset_in,  // Synchronous reset, active high
  input  wire logic         en_in,     // Clock enable
  input  wire logic [W-1:0] d_in,      // Level from the other domain
  output logic      [W-1:0] q_out      // Synchronised level
);

  logic [W-1:0] meta_q;

  // Only the second stage is read outside this module
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      meta_q <= '0;
      q_out  <= '0;
    end else if (en_in) begin
      meta_q <= d_in;
      q_out  <= meta_q;
    end
  end

endmodule
`default_nettype wire

// ---- hdl/jbs_tap_port.sv ----
// Boundary-scan test access port with identification, signature and configuration-load registers
`timescale 1ns/10ps
`include "jbs_defs.svh"
`default_nettype none
module jbs_tap_port #(
  parameter int                            BSR_LEN    = `JBS_BSR_LEN_DEF,
  parameter int                            CFG_W      = `JBS_CFG_W_DEF,
  parameter logic [3:0]                    ID_VERSION = 4'h3,     // Arbitrary value
  parameter logic [15:0]                   ID_PART    = 16'h5a5a, // Arbitrary value
  parameter logic [10:0]                   ID_MAKER   = 11'h2a5,  // Arbitrary value
  parameter logic [`JBS_UC_FIXED_LEN-1:0]  UC_FIXED   = 25'h0c3c3c3
) (
  input  wire logic                          clk_in,        // Core clock
  input  wire logic                          reset_in,      // Synchronous reset, active high
  input  wire logic                          clk_en_in,     // Freezes all state but the reset/enable synchroniser while low
  input  wire logic                          tck_in,        // Test clock from host
  input  wire logic                          tms_in,        // Test mode select
  input  wire logic                          tdi_in,        // Test data in
  output logic                               tdo_out,       // Test data out
  output logic                               tdo_oe_out,    // High while TDO is driven
  output logic                               pullup_en_out, // Weak pull-up on test inputs
  input  wire logic [BSR_LEN/3-1:0]          pin_in,        // Pad input levels
  output logic      [BSR_LEN/3-1:0]          pin_out,       // Pad output levels
  output logic      [BSR_LEN/3-1:0]          pin_oe_out,    // Pad output enables
  input  wire logic [BSR_LEN/3-1:0]          core_out_in,   // Core output levels
  input  wire logic [BSR_LEN/3-1:0]          core_oe_in,    // Core output enables
  input  wire logic [`JBS_UC_USER_LEN-1:0]   user_code_in,  // User signature bits
  input  wire logic                          cfg_busy_in,   // Configuration in progress
  output logic      [CFG_W-1:0]              cfg_data_out,  // Configuration word
  output logic                               cfg_valid_out, // Pulse: new word
  output logic                               cfg_select_out,// Load instruction active
  output logic                               test_mode_out  // Pins under scan control
);

  localparam int NPIN  = BSR_LEN / `JBS_CELLS_PER_PIN;
  localparam int CNT_W = $clog2(CFG_W);
  localparam int TW    = BSR_LEN + `JBS_UC_USER_LEN;
  localparam int CW    = 2 * NPIN + 3;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(CFG_W - 1);

  // Test-clock domain control
  logic [1:0]                    ctl_t;
  logic                          reset_t;
  logic                          en_t;
  logic [TW-1:0]                 in_t;
  logic [NPIN-1:0]               pin_t;
  logic [NPIN-1:0]               core_out_t;
  logic [NPIN-1:0]               core_oe_t;
  logic [`JBS_UC_USER_LEN-1:0]   user_t;

  jbs_pkg::jbs_tap_state_type    state_q;
  jbs_pkg::jbs_tap_state_type    state_d;
  jbs_pkg::jbs_dr_sel_type       dr_sel;
  logic [`JBS_IR_LEN-1:0]        ir_sh_q;
  logic [`JBS_IR_LEN-1:0]        ir_q;
  logic                          byp_q;
  logic [`JBS_ID_LEN-1:0]        id_sh_q;
  logic [`JBS_UC_LEN-1:0]        uc_sh_q;
  logic [BSR_LEN-1:0]            bsr_sh_q;
  logic [NPIN-1:0]               upd_out_q;
  logic [NPIN-1:0]               upd_oe_q;
  logic                          extest_q;
  logic [CFG_W-1:0]              cfg_sh_q;
  logic [CFG_W-1:0]              cfg_word_q;
  logic [CNT_W-1:0]              cfg_cnt_q;
  logic                          cfg_tog_q;
  logic                          tdo_d;
  logic [`JBS_ID_LEN-1:0]        id_word;

  // Core-clock domain
  logic [CW-1:0]                 to_c;
  logic [NPIN-1:0]               upd_out_c;
  logic [NPIN-1:0]               upd_oe_c;
  logic                          extest_c;
  logic                          cfg_sel_c;
  logic                          cfg_tog_c;
  logic                          tog_prev_q;
  logic                          drive_c;

  assign id_word = {ID_VERSION, ID_PART, ID_MAKER, 1'b1};
  assign pullup_en_out = 1'b1;

  // Reset and enable enter the test-clock domain; this pair is never frozen
  jbs_sync #(
    .W (2)
  ) u_ctl_sync (
    .clk_in   (tck_in),
    .reset_in (1'b0),
    .en_in    (1'b1),
    .d_in     ({clk_en_in, reset_in}),
    .q_out    (ctl_t)
  );
  assign reset_t = ctl_t[0];
  assign en_t    = ctl_t[1];

  // Pad and core levels are sampled in the test-clock domain for capture
  jbs_sync #(
    .W (TW)
  ) u_in_sync (
    .clk_in   (tck_in),
    .reset_in (reset_t),
    .en_in    (en_t),
    .d_in     ({user_code_in, core_oe_in, core_out_in, pin_in}),
    .q_out    (in_t)
  );
  assign pin_t      = in_t[NPIN-1:0];
  assign core_out_t = in_t[2*NPIN-1:NPIN];
  assign core_oe_t  = in_t[3*NPIN-1:2*NPIN];
  assign user_t     = in_t[TW-1:BSR_LEN];

  // Controller next state
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      jbs_pkg::st_reset:    state_d = tms_in ? jbs_pkg::st_reset   : jbs_pkg::st_idle;
      jbs_pkg::st_idle:     state_d = tms_in ? jbs_pkg::st_sel_dr  : jbs_pkg::st_idle;
      jbs_pkg::st_sel_dr:   state_d = tms_in ? jbs_pkg::st_sel_ir  : jbs_pkg::st_cap_dr;
      jbs_pkg::st_cap_dr:   state_d = tms_in ? jbs_pkg::st_exit1_dr : jbs_pkg::st_shift_dr;
      jbs_pkg::st_shift_dr: state_d = tms_in ? jbs_pkg::st_exit1_dr : jbs_pkg::st_shift_dr;
      jbs_pkg::st_exit1_dr: state_d = tms_in ? jbs_pkg::st_upd_dr  : jbs_pkg::st_pause_dr;
      jbs_pkg::st_pause_dr: state_d = tms_in ? jbs_pkg::st_exit2_dr : jbs_pkg::st_pause_dr;
      jbs_pkg::st_exit2_dr: state_d = tms_in ? jbs_pkg::st_upd_dr  : jbs_pkg::st_shift_dr;
      jbs_pkg::st_upd_dr:   state_d = tms_in ? jbs_pkg::st_sel_dr  : jbs_pkg::st_idle;
      jbs_pkg::st_sel_ir:   state_d = tms_in ? jbs_pkg::st_reset   : jbs_pkg::st_cap_ir;
      jbs_pkg::st_cap_ir:   state_d = tms_in ? jbs_pkg::st_exit1_ir : jbs_pkg::st_shift_ir;
      jbs_pkg::st_shift_ir: state_d = tms_in ? jbs_pkg::st_exit1_ir : jbs_pkg::st_shift_ir;
      jbs_pkg::st_exit1_ir: state_d = tms_in ? jbs_pkg::st_upd_ir  : jbs_pkg::st_pause_ir;
      jbs_pkg::st_pause_ir: state_d = tms_in ? jbs_pkg::st_exit2_ir : jbs_pkg::st_pause_ir;
      jbs_pkg::st_exit2_ir: state_d = tms_in ? jbs_pkg::st_upd_ir  : jbs_pkg::st_shift_ir;
      jbs_pkg::st_upd_ir:   state_d = tms_in ? jbs_pkg::st_sel_dr  : jbs_pkg::st_idle;
    endcase
  end

  always_ff @(posedge tck_in) begin
    if (reset_t) begin
      state_q <= jbs_pkg::st_reset;
    end else if (en_t) begin
      state_q <= state_d;
    end
  end

  // Unknown opcodes fall back to the bypass register, as the standard demands
  always_comb begin
    unique case (ir_q)
      `JBS_IR_EXTEST,
      `JBS_IR_SAMPLE:   dr_sel = jbs_pkg::sel_bsr;
      `JBS_IR_IDCODE:   dr_sel = jbs_pkg::sel_id;
      `JBS_IR_USERCODE: dr_sel = jbs_pkg::sel_uc;
      `JBS_IR_CFG_LOAD: dr_sel = jbs_pkg::sel_cfg;
      default:          dr_sel = jbs_pkg::sel_bypass;
    endcase
  end

  // Instruction register: ten-bit shift stage and parallel update stage
  always_ff @(posedge tck_in) begin
    if (reset_t) begin
      ir_sh_q <= `JBS_IR_CAPTURE;
      ir_q    <= `JBS_IR_RESET_VAL;
    end else if (en_t) begin
      unique case (state_q)
        jbs_pkg::st_reset:    ir_q    <= `JBS_IR_RESET_VAL;
        jbs_pkg::st_cap_ir:   ir_sh_q <= `JBS_IR_CAPTURE;
        jbs_pkg::st_shift_ir: ir_sh_q <= {tdi_in, ir_sh_q[`JBS_IR_LEN-1:1]};
        jbs_pkg::st_upd_ir:   ir_q    <= ir_sh_q;
        default: ;
      endcase
    end
  end

  // Bypass, identification and signature registers
  always_ff @(posedge tck_in) begin
    if (reset_t) begin
      byp_q   <= `JBS_BYPASS_CAPTURE;
      id_sh_q <= '0;
      uc_sh_q <= '0;
    end else if (en_t) begin
      if (state_q == jbs_pkg::st_cap_dr) begin
        byp_q   <= `JBS_BYPASS_CAPTURE;
        id_sh_q <= id_word;
        uc_sh_q <= {UC_FIXED, user_t};
      end else if (state_q == jbs_pkg::st_shift_dr) begin
        if (dr_sel == jbs_pkg::sel_bypass) begin
          byp_q <= tdi_in;
        end
        if (dr_sel == jbs_pkg::sel_id) begin
          id_sh_q <= {tdi_in, id_sh_q[`JBS_ID_LEN-1:1]};
        end
        if (dr_sel == jbs_pkg::sel_uc) begin
          uc_sh_q <= {tdi_in, uc_sh_q[`JBS_UC_LEN-1:1]};
        end
      end
    end
  end

  // Boundary chain: cell 3k input, 3k+1 output, 3k+2 enable; cell 0 sits next to TDO
  always_ff @(posedge tck_in) begin
    if (reset_t) begin
      bsr_sh_q <= '0;
    end else if (en_t && dr_sel == jbs_pkg::sel_bsr) begin
      if (state_q == jbs_pkg::st_cap_dr) begin
        for (int k = 0; k < NPIN; k++) begin
          bsr_sh_q[3*k]   <= pin_t[k];
          bsr_sh_q[3*k+1] <= core_out_t[k];
          bsr_sh_q[3*k+2] <= core_oe_t[k];
        end
      end else if (state_q == jbs_pkg::st_shift_dr) begin
        bsr_sh_q <= {tdi_in, bsr_sh_q[BSR_LEN-1:1]};
      end
    end
  end

  // Update stage; preload under SAMPLE only stores, EXTEST then drives it
  always_ff @(posedge tck_in) begin
    if (reset_t) begin
      upd_out_q <= '0;
      upd_oe_q  <= '0;
      extest_q  <= 1'b0;
    end else if (en_t) begin
      if (state_q == jbs_pkg::st_upd_dr && dr_sel == jbs_pkg::sel_bsr) begin
        for (int k = 0; k < NPIN; k++) begin
          upd_out_q[k] <= bsr_sh_q[3*k+1];
          upd_oe_q[k]  <= bsr_sh_q[3*k+2];
        end
      end
      // Takes the new opcode at Update-IR itself: the test clock may stop right after it
      extest_q <= (state_q == jbs_pkg::st_upd_ir) ? (ir_sh_q == `JBS_IR_EXTEST) : (ir_q == `JBS_IR_EXTEST);
    end
  end

  // Configuration words gather here; a toggle announces each full word
  always_ff @(posedge tck_in) begin
    if (reset_t) begin
      cfg_sh_q   <= '0;
      cfg_word_q <= '0;
      cfg_cnt_q  <= '0;
      cfg_tog_q  <= 1'b0;
    end else if (en_t && dr_sel == jbs_pkg::sel_cfg) begin
      if (state_q == jbs_pkg::st_cap_dr) begin
        cfg_cnt_q <= '0;
      end else if (state_q == jbs_pkg::st_shift_dr) begin
        cfg_sh_q  <= {tdi_in, cfg_sh_q[CFG_W-1:1]};
        cfg_cnt_q <= cfg_cnt_q + 1'b1;
        if (cfg_cnt_q == CNT_LAST) begin
          cfg_word_q <= {tdi_in, cfg_sh_q[CFG_W-1:1]};
          cfg_tog_q  <= ~cfg_tog_q;
          cfg_cnt_q  <= '0;
        end
      end
    end
  end

  always_comb begin
    tdo_d = byp_q;
    if (state_q == jbs_pkg::st_shift_ir) begin
      tdo_d = ir_sh_q[0];
    end else begin
      unique case (dr_sel)
        jbs_pkg::sel_bsr:    tdo_d = bsr_sh_q[0];
        jbs_pkg::sel_id:     tdo_d = id_sh_q[0];
        jbs_pkg::sel_uc:     tdo_d = uc_sh_q[0];
        jbs_pkg::sel_cfg:    tdo_d = cfg_sh_q[0];
        jbs_pkg::sel_bypass: tdo_d = byp_q;
      endcase
    end
  end

  // TDO changes on the falling edge so the host samples it mid-period
  always_ff @(negedge tck_in) begin
    if (reset_t) begin
      tdo_out    <= 1'b0;
      tdo_oe_out <= 1'b0;
    end else if (en_t) begin
      tdo_out    <= tdo_d;
      tdo_oe_out <= (state_q == jbs_pkg::st_shift_dr) || (state_q == jbs_pkg::st_shift_ir);
    end
  end

  // Update pattern is quasi-static: it only changes at Update-DR, so per-bit sync is safe
  jbs_sync #(
    .W (CW)
  ) u_out_sync (
    .clk_in   (clk_in),
    .reset_in (reset_in),
    .en_in    (clk_en_in),
    .d_in     ({cfg_tog_q, (dr_sel == jbs_pkg::sel_cfg), extest_q, upd_oe_q, upd_out_q}),
    .q_out    (to_c)
  );
  assign upd_out_c = to_c[NPIN-1:0];
  assign upd_oe_c  = to_c[2*NPIN-1:NPIN];
  assign extest_c  = to_c[2*NPIN];
  assign cfg_sel_c = to_c[2*NPIN+1];
  assign cfg_tog_c = to_c[2*NPIN+2];

  assign drive_c = extest_c & ~cfg_busy_in;

  // Pads follow the core except while EXTEST drives them
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      pin_out       <= '0;
      pin_oe_out    <= '0;
      test_mode_out <= 1'b0;
    end else if (clk_en_in) begin
      pin_out       <= drive_c ? upd_out_c : core_out_in;
      pin_oe_out    <= drive_c ? upd_oe_c  : core_oe_in;
      test_mode_out <= drive_c;
    end
  end

  // The word register holds for a whole word time after its toggle, so it is read directly
  always_ff @(posedge clk_in) begin
    if (reset_in) begin
      tog_prev_q     <= 1'b0;
      cfg_valid_out  <= 1'b0;
      cfg_data_out   <= '0;
      cfg_select_out <= 1'b0;
    end else if (clk_en_in) begin
      tog_prev_q     <= cfg_tog_c;
      cfg_valid_out  <= cfg_tog_c ^ tog_prev_q;
      cfg_select_out <= cfg_sel_c;
      if (cfg_tog_c ^ tog_prev_q) begin
        cfg_data_out <= cfg_word_q;
      end
    end
  end

endmodule
`default_nettype wire

// ---- test/jbs_host_model.sv ----
// Behavioural test-port host: clocks TMS/TDI and collects TDO
`timescale 1ns/10ps
`default_nettype none
module jbs_host_model (
  output logic      tck_out, // Test clock, still between scans
  output logic      tms_out, // Test mode select
  output logic      tdi_out, // Test data, high when idle
  input  wire logic tdo_in   // Test data back
);
  initial begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b1;
  end
  // Signals change at the falling edge and are held through the rising edge
  task automatic step(input logic m, input logic d, output logic o);
    tms_out = m;
    tdi_out = d;
    #40 tck_out = 1'b1;
    o = tdo_in;
    #40 tck_out = 1'b0;
  endtask
  task automatic reset_tap();
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
  endtask
  // Exactly n bits per scan, LSB first, from and back to run-test/idle
  task automatic scan(input logic ir, input int n, input logic [63:0] din, output logic [63:0] dout);
    logic o;
    dout = '0;
    step(1'b1, 1'b1, o);
    if (ir) step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    step(1'b0, 1'b1, o);
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], o);
      dout[i] = o;
    end
    step(1'b1, 1'b1, o);
    step(1'b0, 1'b1, o);
    tdi_out = 1'b1;
  endtask
endmodule
`default_nettype wire

// ---- test/jbs_tap_port_bench.sv ----
// Self-checking bench for the boundary-scan test port
`timescale 1ns/10ps
`include "jbs_defs.svh"
`default_nettype none
module jbs_tap_port_bench;
  localparam logic [31:0] ID_EXP = {4'h3, 16'h5a5a, 11'h2a5, 1'b1}; // Arbitrary identity values
  localparam logic [24:0] UC_FIX = 25'h0c3c3c3;
  logic        clk_in, reset_in, tck, tms, tdi, tdo, tdo_oe, pullup_en;
  logic [1:0]  pin_in, pin_out, pin_oe, core_out, core_oe;
  logic [6:0]  user_code;
  logic        cfg_busy, cfg_valid, cfg_select, test_mode;
  logic [7:0]  cfg_data;
  logic [7:0]  cfg_q[$];
  logic [63:0] dout;
  int          mismatches, comparisons, cycles;

  jbs_tap_port #(.BSR_LEN(6), .CFG_W(8), .ID_VERSION(ID_EXP[31:28]), .ID_PART(ID_EXP[27:12]),
    .ID_MAKER(ID_EXP[11:1]), .UC_FIXED(UC_FIX)) jbs_tap_port_i (
    .clk_in(clk_in), .reset_in(reset_in), .clk_en_in(1'b1), .tck_in(tck), .tms_in(tms), .tdi_in(tdi),
    .tdo_out(tdo), .tdo_oe_out(tdo_oe), .pullup_en_out(pullup_en), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe_out(pin_oe), .core_out_in(core_out), .core_oe_in(core_oe), .user_code_in(user_code),
    .cfg_busy_in(cfg_busy), .cfg_data_out(cfg_data), .cfg_valid_out(cfg_valid),
    .cfg_select_out(cfg_select), .test_mode_out(test_mode));
  // Released TDO reads as the pulled-up level, never as a stale bit
  jbs_host_model jbs_host_model_i (.tck_out(tck), .tms_out(tms), .tdi_out(tdi), .tdo_in(tdo_oe ? tdo : 1'b1));

  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) if (cfg_valid === 1'b1) cfg_q.push_back(cfg_data);
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      $display("[ERR] %0t timeout", $time);
      print_verdict();
    end
  end

  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic check(input logic [63:0] got, input logic [63:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic load_ir(input logic [9:0] op);
    jbs_host_model_i.scan(1'b1, 10, {54'h0, op}, dout);
    check(dout, 64'h001, "instruction capture");
  endtask
  // Cell 3k is the pad input, 3k+1 the core level, 3k+2 the core enable
  function automatic logic [5:0] cap_exp();
    logic [5:0] e;
    for (int k = 0; k < 2; k++) e[3*k +: 3] = {core_oe[k], core_out[k], pin_in[k]};
    return e;
  endfunction
  task automatic wait_pins(input logic [1:0] po, input logic [1:0] oe, input string what);
    int n;
    n = 0;
    while ((pin_out !== po || pin_oe !== oe) && n < 40) begin
      @(negedge clk_in);
      n++;
    end
    check({pin_oe, pin_out}, {oe, po}, what);
  endtask

  task automatic t_idcode();
    jbs_host_model_i.scan(1'b0, 32, 64'h0, dout);
    check(dout, {32'h0, ID_EXP}, "default register");
    load_ir(`JBS_IR_IDCODE);
    jbs_host_model_i.scan(1'b0, 32, 64'hffffffff, dout);
    check(dout, {32'h0, ID_EXP}, "identification");
    $display("test idcode done");
  endtask
  task automatic t_user();
    @(negedge clk_in) user_code = 7'h5b;
    load_ir(`JBS_IR_USERCODE);
    jbs_host_model_i.scan(1'b0, 32, 64'h0, dout);
    check(dout, {32'h0, UC_FIX, 7'h5b}, "user signature");
    $display("test usercode done");
  endtask
  task automatic t_bypass();
    logic [9:0] ops[2];
    ops = '{`JBS_IR_BYPASS, 10'h123};
    foreach (ops[i]) begin
      load_ir(ops[i]);
      jbs_host_model_i.scan(1'b0, 9, 64'h1a5, dout);
      check(dout, 64'h14a, "one-stage delay");
    end
    $display("test bypass done");
  endtask
  task automatic t_boundary();
    @(negedge clk_in);
    pin_in = 2'b10;
    core_out = 2'b10;
    core_oe = 2'b11;
    load_ir(`JBS_IR_SAMPLE);
    jbs_host_model_i.scan(1'b0, 6, 64'h06, dout);
    check(dout, {58'h0, cap_exp()}, "sample snapshot");
    repeat (10) @(negedge clk_in);
    check({test_mode, pin_oe, pin_out}, {1'b0, core_oe, core_out}, "pins undisturbed");
    load_ir(`JBS_IR_EXTEST);
    wait_pins(2'b01, 2'b01, "preload driven");
    check(test_mode, 1'b1, "scan control");
    jbs_host_model_i.scan(1'b0, 6, 64'h20, dout);
    check(dout, {58'h0, cap_exp()}, "extest capture");
    wait_pins(2'b00, 2'b10, "extest drive");
    @(negedge clk_in) cfg_busy = 1'b1;
    wait_pins(core_out, core_oe, "configuring blocks drive");
    @(negedge clk_in) cfg_busy = 1'b0;
    wait_pins(2'b00, 2'b10, "drive resumes");
    $display("test boundary done");
  endtask
  task automatic t_cfg();
    load_ir(`JBS_IR_CFG_LOAD);
    cfg_q.delete();
    jbs_host_model_i.scan(1'b0, 20, 64'h3c35a, dout);
    repeat (10) @(negedge clk_in);
    check(cfg_select, 1'b1, "load instruction active");
    check(cfg_q.size(), 2, "whole words only");
    check({cfg_q[1], cfg_q[0]}, 16'hc35a, "config words");
    $display("test config load done");
  endtask

  initial begin
    clk_in = 1'b0;
    reset_in = 1'b1;
    pin_in = '0;
    core_out = '0;
    core_oe = '0;
    user_code = '0;
    cfg_busy = 1'b0;
    mismatches = 0;
    comparisons = 0;
    cycles = 0;
    fork
      jbs_host_model_i.reset_tap();
      repeat (5) @(posedge clk_in);
    join
    @(negedge clk_in) reset_in = 1'b0;
    jbs_host_model_i.reset_tap();
    check(pullup_en, 1'b1, "pull-up enable");
    t_idcode();
    t_user();
    t_bypass();
    t_boundary();
    t_cfg();
    print_verdict();
  end
endmodule
`default_nettype wire

// ---- test/jbs_tap_port_properties.sv ----
// Checker for the boundary-scan test port, bound to its ports
`timescale 1ns/10ps
`include "jbs_defs.svh"
`default_nettype none
module jbs_tap_props #(
  parameter int BSR_LEN = `JBS_BSR_LEN_DEF
) (
  input wire logic                 clk_in,         // Core clock
  input wire logic                 reset_in,       // Synchronous reset
  input wire logic                 tck_in,         // Test clock
  input wire logic                 tms_in,         // Test mode select
  input wire logic                 tdo_oe_out,     // TDO drive enable
  input wire logic                 pullup_en_out,  // Weak pull-up enable
  input wire logic [BSR_LEN/3-1:0] pin_out,        // Pad levels
  input wire logic [BSR_LEN/3-1:0] pin_oe_out,     // Pad enables
  input wire logic [BSR_LEN/3-1:0] core_out_in,    // Core levels
  input wire logic [BSR_LEN/3-1:0] core_oe_in,     // Core enables
  input wire logic                 cfg_busy_in,    // Configuring
  input wire logic                 cfg_valid_out,  // Word strobe
  input wire logic                 cfg_select_out, // Load instruction active
  input wire logic                 test_mode_out   // Pins under scan control
);
  a_pullup_held: assert property (@(posedge clk_in) disable iff (reset_in) pullup_en_out == 1'b1)
    else $error("pull-up enable dropped");
  a_word_spacing: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_valid_out |=> !cfg_valid_out [*5]) else $error("config words too close");
  a_word_selected: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_valid_out |-> cfg_select_out) else $error("config word without load instruction");
  a_pins_follow_core: assert property (@(posedge clk_in) disable iff (reset_in)
    !test_mode_out && !$past(test_mode_out) && !$past(reset_in)
    |-> pin_out == $past(core_out_in) && pin_oe_out == $past(core_oe_in))
    else $error("pins differ from core outside scan control");
  a_busy_no_scan: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_busy_in [*3] |-> !test_mode_out) else $error("scan drive while configuring");
  a_busy_pins_core: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_busy_in [*3] |-> pin_out == $past(core_out_in) && pin_oe_out == $past(core_oe_in))
    else $error("pins not from core while configuring");
  a_tms_leaves_shift: assert property (@(posedge tck_in) disable iff (reset_in)
    tms_in |=> !tdo_oe_out) else $error("TDO driven outside a shift state");
  a_modes_exclusive: assert property (@(posedge clk_in) disable iff (reset_in)
    cfg_select_out |-> !test_mode_out) else $error("scan drive during config load");
endmodule
bind jbs_tap_port jbs_tap_props #(.BSR_LEN(BSR_LEN)) jbs_tap_props_i (
  .clk_in(clk_in), .reset_in(reset_in), .tck_in(tck_in), .tms_in(tms_in), .tdo_oe_out(tdo_oe_out),
  .pullup_en_out(pullup_en_out), .pin_out(pin_out), .pin_oe_out(pin_oe_out), .core_out_in(core_out_in),
  .core_oe_in(core_oe_in), .cfg_busy_in(cfg_busy_in), .cfg_valid_out(cfg_valid_out),
  .cfg_select_out(cfg_select_out), .test_mode_out(test_mode_out));
`default_nettype wire
